// *** include/ums_pkg.sv ***
/*
  Constants and state layout for the host select and modem status block.
  Assumes a single 10 MHz clock and a host bus that is sampled through
  two-flop synchronisers inside the block.
*/
// Summary of operation
// - Selected only with both positive selects high and negative select low.
// - Address strobe low passes selects through; high holds the last captured value.
// - Eight-bit data path driven only during a selected read, else released.
// - Status byte shows clear-to-send bit 4, data-set-ready bit 5, carrier bit 7.
// - Change bits 0, 1, 3 record level changes since the last status read.
// - Clear-to-send change interrupts only when enabled and auto mode is off.
// - Data-set-ready or carrier change interrupts when enabled at change time and still enabled.
// - Auto clear-to-send mode gates the transmitter with the input.
// - Terminal-ready output goes low when its control bit is set and loopback is off.
// - Terminal-ready inactive on master reset, loopback, or cleared control bit.
// - Driver-off output low whenever the host is not reading.
// - Interrupt high for receiver error, data, empty holding, modem event.
// - Interrupt drops when serviced or on master reset.
// - Master reset clears state and drives outputs to reset levels.
package ums_pkg;

  // Data path width
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  // Register select value of the modem status byte
  localparam logic [2:0] MSR_ADDR = 3'h6;

  // Field positions in the modem status byte
  localparam int unsigned MSR_DCTS = 0;
  localparam int unsigned MSR_DDSR = 1;
  localparam int unsigned MSR_DDCD = 3;
  localparam int unsigned MSR_CTS  = 4;
  localparam int unsigned MSR_DSR  = 5;
  localparam int unsigned MSR_DCD  = 7;

  // Reset values
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [2:0] DELTA_RST = 3'h0;
  localparam logic [2:0] LINE_RST  = 3'h7;

  // Synchronised pin bundle: selects, strobes, modem lines
  typedef struct packed {
    logic       cs_a;
    logic       cs_b;
    logic       cs_neg;
    logic       as_n;
    logic [2:0] sel;
    logic       rd;
    logic       wr;
    logic [2:0] line_n;  // {dcd_n, dsr_n, cts_n}
    logic       mr;
    logic [7:0] data;
  } ums_pins_t;

  // Whole block state
  typedef struct packed {
    ums_pins_t  s1;
    ums_pins_t  s2;
    logic       cs_hold;
    logic [2:0] sel_hold;
    logic [2:0] line_prev;
    logic [2:0] delta;
    logic       msi_pend;
    logic       rd_prev;
    logic       wr_prev;
    logic [7:0] dout;
    logic       oe;
    logic       drv_off_n;
    logic       dtr_n;
    logic       irq;
    logic       tx_allow;
    logic       wr_stb;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic       rd_stb;
    logic [2:0] rd_addr;
  } ums_state_t;

endpackage

// *** core/ums_host_modem.sv ***
/*
  Host select decode, tri-state data path control, driver-off output,
  interrupt output and modem status tracking for a FIFO UART.
  Assumes every host and modem pin is asynchronous to i_clk, and that the
  rest of the UART supplies read data, interrupt sources and control bits
  on i_clk. The bidirectional data bus is split into in, out and enable;
  the surrounding wiring resolves the pad.
*/
`timescale 1ns/1ps

module ums_host_modem (
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  // Host select and strobes (pins)
  input  wire logic                           i_chip_sel_pos_a,
  input  wire logic                           i_chip_sel_pos_b,
  input  wire logic                           i_chip_sel_neg,
  input  wire logic                           i_addr_strobe_n,
  input  wire logic [ums_pkg::ADDR_W-1:0]     i_reg_select,
  input  wire logic                           i_read,
  input  wire logic                           i_write,
  input  wire logic                           i_master_reset_in,
  // Host data bus (pins, split)
  input  wire logic [ums_pkg::DATA_W-1:0]     i_host_data_bus,
  output logic      [ums_pkg::DATA_W-1:0]     o_host_data_bus,
  output logic                                o_host_data_bus_oe,
  output logic                                o_xcvr_driver_off_n,
  // Modem lines (pins)
  input  wire logic                           i_cts_n,
  input  wire logic                           i_dsr_n,
  input  wire logic                           i_dcd_n,
  output logic                                o_dtr_n,
  // Control bits from the UART core
  input  wire logic                           i_dtr_ctl,
  input  wire logic                           i_loopback,
  input  wire logic                           i_msi_en,
  input  wire logic                           i_auto_cts_en,
  // Interrupt sources from the UART core
  input  wire logic                           i_rx_err_irq,
  input  wire logic                           i_rx_data_irq,
  input  wire logic                           i_thr_empty_irq,
  // Register access towards the UART core
  input  wire logic [ums_pkg::DATA_W-1:0]     i_core_rd_data,
  output logic                                o_rd_stb,
  output logic      [ums_pkg::ADDR_W-1:0]     o_rd_addr,
  output logic                                o_wr_stb,
  output logic      [ums_pkg::ADDR_W-1:0]     o_wr_addr,
  output logic      [ums_pkg::DATA_W-1:0]     o_wr_data,
  // Status towards the UART core
  output logic                                o_tx_allow,
  output logic                                o_irq
);
  import ums_pkg::*;

  ums_state_t q;
  ums_state_t d;

  // Decode helpers
  logic       cs_live;
  logic       cs_eff;
  logic [2:0] sel_eff;
  logic       rd_act;
  logic       wr_act;
  logic       rd_end;
  logic       wr_start;
  logic       msr_rd_end;
  logic [2:0] line_now;
  logic [2:0] change;
  logic [2:0] change_en;
  logic [7:0] msr;
  logic       reset_all;

  // Next state of the whole block
  always_comb begin
    d = q;
    cs_live   = 1'b0;
    cs_eff    = 1'b0;
    sel_eff   = 3'h0;
    rd_act    = 1'b0;
    wr_act    = 1'b0;
    rd_end    = 1'b0;
    wr_start  = 1'b0;
    msr_rd_end = 1'b0;
    line_now  = 3'h0;
    change    = 3'h0;
    change_en = 3'h0;
    msr       = 8'h00;
    reset_all = 1'b0;

    // Two-flop synchronisers; stage one feeds only stage two
    d.s1.cs_a   = i_chip_sel_pos_a;
    d.s1.cs_b   = i_chip_sel_pos_b;
    d.s1.cs_neg = i_chip_sel_neg;
    d.s1.as_n   = i_addr_strobe_n;
    d.s1.sel    = i_reg_select;
    d.s1.rd     = i_read;
    d.s1.wr     = i_write;
    d.s1.line_n = {i_dcd_n, i_dsr_n, i_cts_n};
    d.s1.mr     = i_master_reset_in;
    d.s1.data   = i_host_data_bus;
    d.s2        = q.s1;

    // All three selects must agree before the part responds
    cs_live = q.s2.cs_a & q.s2.cs_b & ~q.s2.cs_neg;

    // Transparent while strobe low, frozen while high
    if (!q.s2.as_n) begin
      d.cs_hold  = cs_live;
      d.sel_hold = q.s2.sel;
    end
    cs_eff  = q.s2.as_n ? q.cs_hold : cs_live;
    sel_eff = q.s2.as_n ? q.sel_hold : q.s2.sel;

    // Strobes count only while selected
    rd_act   = cs_eff & q.s2.rd;
    wr_act   = cs_eff & q.s2.wr;
    d.rd_prev = rd_act;
    d.wr_prev = wr_act;
    rd_end   = q.rd_prev & ~rd_act;
    wr_start = wr_act & ~q.wr_prev;
    // Clear on the end of the read so the host sees the bits it reads
    msr_rd_end = rd_end & (q.rd_addr == MSR_ADDR);

    // Modem line levels, active high view of active-low pins
    line_now = ~q.s2.line_n;
    d.line_prev = line_now;
    change = line_now ^ q.line_prev;

    // Change bits: a new change wins over the read clear
    for (int i = 0; i < 3; i++) begin
      d.delta[i] = (q.delta[i] & ~msr_rd_end) | change[i];
    end

    // Clear-to-send changes are silent in auto mode
    change_en[0] = change[0] & ~i_auto_cts_en;
    change_en[1] = change[1];
    change_en[2] = change[2];
    // Enable is sampled at the moment of the change
    d.msi_pend = (q.msi_pend & ~msr_rd_end) | (i_msi_en & (|change_en));

    // Status byte as the host reads it
    msr[MSR_DCTS] = q.delta[0];
    msr[MSR_DDSR] = q.delta[1];
    msr[MSR_DDCD] = q.delta[2];
    msr[MSR_CTS]  = line_now[0];
    msr[MSR_DSR]  = line_now[1];
    msr[MSR_DCD]  = line_now[2];

    // Read data path: drive only during a selected read
    d.oe = rd_act;
    if (rd_act) begin
      d.dout = (sel_eff == MSR_ADDR) ? msr : i_core_rd_data;
    end else begin
      d.dout = DATA_RST;
    end
    d.rd_addr = rd_act ? sel_eff : q.rd_addr;
    d.rd_stb  = rd_end;

    // Transceiver may drive toward the host only during a read
    d.drv_off_n = rd_act;

    // Write capture on the leading edge of the strobe
    d.wr_stb = wr_start;
    if (wr_start) begin
      d.wr_addr = sel_eff;
      d.wr_data = q.s2.data;
    end

    // Terminal ready: low only when commanded and not looping back
    d.dtr_n = ~(i_dtr_ctl & ~i_loopback);

    // Auto mode lets the transmitter run only while clear-to-send is active
    d.tx_allow = ~i_auto_cts_en | line_now[0];

    // Interrupt follows pending sources; each clears when serviced
    d.irq = i_rx_err_irq | i_rx_data_irq | i_thr_empty_irq |
            (q.msi_pend & i_msi_en);

    // Master reset pin acts like the block reset, after synchronising
    reset_all = i_rst | q.s2.mr;
    if (reset_all) begin
      d.cs_hold   = 1'b0;
      d.sel_hold  = 3'h0;
      d.line_prev = line_now;  // Track levels so no change shows once reset lifts
      d.delta     = DELTA_RST;
      d.msi_pend  = 1'b0;
      d.rd_prev   = 1'b0;
      d.wr_prev   = 1'b0;
      d.dout      = DATA_RST;
      d.oe        = 1'b0;
      d.drv_off_n = 1'b0;
      d.dtr_n     = 1'b1;
      d.irq       = 1'b0;
      d.tx_allow  = 1'b1;
      d.wr_stb    = 1'b0;
      d.wr_addr   = 3'h0;
      d.wr_data   = DATA_RST;
      d.rd_stb    = 1'b0;
      d.rd_addr   = 3'h0;
    end
    // Synchronisers restart only on the block reset, so the pin can lift
    if (i_rst) begin
      d.s1 = '0;
      d.s2 = '0;
      // Modem pins idle high; a zero here would fake a change after reset
      d.s1.line_n = LINE_RST;
      d.s2.line_n = LINE_RST;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // Outputs straight from flip-flops
  assign o_host_data_bus     = q.dout;
  assign o_host_data_bus_oe  = q.oe;
  assign o_xcvr_driver_off_n = q.drv_off_n;
  assign o_dtr_n             = q.dtr_n;
  assign o_rd_stb            = q.rd_stb;
  assign o_rd_addr           = q.rd_addr;
  assign o_wr_stb            = q.wr_stb;
  assign o_wr_addr           = q.wr_addr;
  assign o_wr_data           = q.wr_data;
  assign o_tx_allow          = q.tx_allow;
  assign o_irq               = q.irq;

endmodule

// *** bench/ums_host_modem_monitor.sv ***
/* Port-level assertions for the host select and modem status block.
   Assumes one clock with i_rst synchronous; bound to ums_host_modem. */
`timescale 1ns/1ps

module ums_host_modem_monitor (
  // Inputs watched
  input wire logic i_clk, i_rst, i_chip_sel_pos_a, i_chip_sel_pos_b, i_chip_sel_neg, i_addr_strobe_n,
  input wire logic i_read, i_master_reset_in, i_cts_n, i_dtr_ctl, i_loopback, i_msi_en, i_auto_cts_en,
  input wire logic i_rx_err_irq, i_rx_data_irq, i_thr_empty_irq,
  // Outputs watched
  input wire logic o_host_data_bus_oe, o_xcvr_driver_off_n, o_dtr_n, o_tx_allow, o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Master reset is synchronised and registered, so give it time to fade
  wire logic core_src = i_rx_err_irq | i_rx_data_irq | i_thr_empty_irq;
  sequence mr_quiet; (!i_master_reset_in)[*8]; endsequence
  // A read ending near the change would clear the pending bit, so keep reads away
  sequence cts_edge;
    $changed(i_cts_n) && i_msi_en && !i_auto_cts_en && !i_read && !$past(i_read);
  endsequence
  sequence cts_wait; (i_msi_en && !i_auto_cts_en && !i_read && !i_master_reset_in)[*4]; endsequence

  chk_dtr_on: assert property (mr_quiet ##0 (i_dtr_ctl && !i_loopback) |=> !o_dtr_n)
    else $error("terminal ready not active");
  chk_dtr_off: assert property (!i_dtr_ctl || i_loopback |=> o_dtr_n)
    else $error("terminal ready not inactive");
  chk_drv_off_idle: assert property ((!i_read)[*4] |=> !o_xcvr_driver_off_n)
    else $error("driver off high without read");
  chk_oe_pair: assert property (o_host_data_bus_oe == o_xcvr_driver_off_n)
    else $error("bus enable and driver off disagree");
  chk_oe_unsel: assert property ((!(i_chip_sel_pos_a && i_chip_sel_pos_b && !i_chip_sel_neg)
    && !i_addr_strobe_n)[*4] |=> !o_host_data_bus_oe)
    else $error("bus driven while not selected");
  chk_cts_irq: assert property (mr_quiet ##0 cts_edge ##1 cts_wait |=> o_irq)
    else $error("clear to send change gave no interrupt");
  chk_core_irq: assert property (mr_quiet ##0 core_src |=> o_irq)
    else $error("core source gave no interrupt");
  chk_irq_clear: assert property (!core_src && !i_msi_en |=> !o_irq)
    else $error("interrupt with nothing pending");
  chk_mr_levels: assert property (i_master_reset_in[*4] |=> o_dtr_n && !o_irq)
    else $error("master reset levels wrong");
  chk_tx_gate: assert property (!i_auto_cts_en |=> o_tx_allow)
    else $error("transmitter gated without auto mode");
endmodule

bind ums_host_modem ums_host_modem_monitor ums_host_modem_monitor_inst (.*);

// *** bench/ums_modem_model.sv ***
/* Modem model driving the three active-low status lines.
   Assumes i_lines holds the wanted levels {carrier, set ready, clear to send}. */
`timescale 1ns/1ps

module ums_modem_model (
  // Clock and command
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  input  wire logic [2:0] i_lines,
  // Lines to the block
  output logic            o_cts_n, o_dsr_n, o_dcd_n
);
  logic [2:0] late_q;
  // A slow modem settles one clock after the command
  always_ff @(posedge i_clk) late_q <= i_lines;
  assign {o_dcd_n, o_dsr_n, o_cts_n} = i_slow ? late_q : i_lines;
endmodule

// *** bench/tb_top.sv ***
/* Self-checking bench for the host select and modem status block.
   Assumes a 10 MHz clock and the modem model beside the design. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_top;
  import ums_pkg::*;
  logic i_clk = 0, i_rst = 1, cs_a = 1, cs_b = 1, cs_n = 0, as_n = 0, rd = 0, wr = 0, mr = 0;
  logic dtr_ctl = 0, loopb = 0, msi = 0, auto_c = 0, rx_err = 0, rx_dat = 0, thr = 0, slow = 0;
  logic [2:0] sel = 0, lines = 3'h7, old_l, dl;
  logic [7:0] din = 0, core_d = 0, d;
  logic [1:0] seen;
  wire logic cts_n, dsr_n, dcd_n, oe, drv, dtr_n, wstb, txa, irq;
  wire logic [7:0] dout, wdat;
  wire logic [2:0] waddr;
  // Pad level: the block when it drives, otherwise the host
  wire logic [7:0] bus = oe ? dout : din;
  int fails = 0, checked = 0, n;
  integer seed = 32'he102303f;
  always #50 i_clk = ~i_clk;

  ums_modem_model ums_modem_model_inst (.i_clk(i_clk), .i_slow(slow), .i_lines(lines),
    .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_dcd_n(dcd_n));
  ums_host_modem ums_host_modem_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_chip_sel_pos_a(cs_a), .i_chip_sel_pos_b(cs_b), .i_chip_sel_neg(cs_n),
    .i_addr_strobe_n(as_n), .i_reg_select(sel), .i_read(rd), .i_write(wr), .i_master_reset_in(mr),
    .i_host_data_bus(bus), .o_host_data_bus(dout), .o_host_data_bus_oe(oe), .o_xcvr_driver_off_n(drv),
    .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_dcd_n(dcd_n), .o_dtr_n(dtr_n), .i_dtr_ctl(dtr_ctl),
    .i_loopback(loopb), .i_msi_en(msi), .i_auto_cts_en(auto_c), .i_rx_err_irq(rx_err),
    .i_rx_data_irq(rx_dat), .i_thr_empty_irq(thr), .i_core_rd_data(core_d), .o_rd_stb(), .o_rd_addr(),
    .o_wr_stb(wstb), .o_wr_addr(waddr), .o_wr_data(wdat), .o_tx_allow(txa), .o_irq(irq));

  // Inputs always move 5 ns after the rising edge
  task automatic step(input int k);
    repeat (k) begin
      @(posedge i_clk);
      #5;
    end
  endtask

  // Host read: selects held for the whole access, sampled mid-read
  task automatic host_rd(input logic [2:0] a, output logic [7:0] q);
    sel = a;
    rd = 1;
    step(5);
    q = dout;
    seen = {oe, drv};
    rd = 0;
    step(6);
  endtask

  function automatic logic [7:0] msr_exp(input logic [2:0] l, input logic [2:0] c);
    return {~l[2], 1'b0, ~l[1], ~l[0], c[2], 1'b0, c[1:0]};
  endfunction

  function automatic logic irq_exp(input logic [2:0] c, input logic m, input logic a);
    return m & (c[2] | c[1] | (c[0] & ~a));
  endfunction

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    step(12);
    i_rst = 0;
    step(3);
    `CHK("reset levels", 5'b00101, {oe, drv, dtr_n, irq, txa})
    $display("test reset done");
    // Random modem traffic, each change read back and cleared
    old_l = 3'h7;
    for (int k = 0; k < 14; k++) begin
      {msi, auto_c, slow} = 3'($random(seed));
      lines = 3'($random(seed));
      step(8);
      dl = lines ^ old_l;
      old_l = lines;
      `CHK("irq", irq_exp(dl, msi, auto_c), irq)
      `CHK("tx allow", ~auto_c | ~lines[0], txa)
      host_rd(MSR_ADDR, d);
      `CHK("status", msr_exp(lines, dl), d)
      `CHK("irq after read", 1'b0, irq)
    end
    host_rd(MSR_ADDR, d);
    `CHK("status quiet", msr_exp(lines, 3'h0), d)
    $display("test modem done");
    // Every inactive select combination is refused
    for (int k = 0; k < 8; k++) begin
      {cs_a, cs_b, cs_n} = 3'(k);
      host_rd(3'h0, d);
      if (k != 6) `CHK("unselected", 2'b00, seen)
    end
    // Strobe high holds the captured select after a select pin drops
    {cs_a, cs_b, cs_n} = 3'h6;
    core_d = 8'($random(seed));
    step(3);
    as_n = 1;
    step(3);
    cs_a = 0;
    host_rd(3'h2, d);
    `CHK("held read", {2'b11, core_d}, {seen, d})
    as_n = 0;
    cs_a = 1;
    $display("test select done");
    // Selected write hands address and data on
    sel = 3'($random(seed));
    din = 8'($random(seed));
    wr = 1;
    for (n = 0; n < 8 && wstb !== 1'b1; n++) step(1);
    if (n == 8) begin
      fails++;
      test_done();
    end
    `CHK("write", {sel, din}, {waddr, wdat})
    wr = 0;
    step(4);
    $display("test write done");
    // Terminal ready over control and loopback
    for (int k = 0; k < 4; k++) begin
      {dtr_ctl, loopb} = 2'(k);
      step(2);
      `CHK("dtr", ~(dtr_ctl & ~loopb), dtr_n)
    end
    // Each core source, then master reset
    msi = 0;
    for (int k = 0; k < 3; k++) begin
      {rx_err, rx_dat, thr} = 3'(1 << k);
      step(2);
      `CHK("core irq", 1'b1, irq)
    end
    // Terminal ready commanded on, so master reset must force it off
    mr = 1;
    {dtr_ctl, loopb} = 2'h2;
    step(5);
    `CHK("mr levels", 2'b10, {dtr_n, irq})
    mr = 0;
    {rx_err, rx_dat, thr} = 3'h0;
    step(8);
    `CHK("after mr", 2'b00, {dtr_n, irq})
    $display("test irq done");
    test_done();
  end
endmodule
